// File: fine_edge_pkg.sv
`default_nettype none
package fine_edge_pkg;
    // register word offsets on the plain register port
    localparam logic [5:0] OFS_PHASE_FINE = 6'h02;
    localparam logic [5:0] OFS_DUTY_FINE  = 6'h08;
    localparam logic [5:0] OFS_CONFIG     = 6'h20;
    localparam logic [5:0] OFS_DIAG_CTRL  = 6'h22;
    localparam logic [5:0] OFS_DIAG_STAT  = 6'h24;
    // field positions
    localparam int STEP_LSB      = 8;  // step count sits in the high byte
    localparam int CFG_EDGE_LSB  = 0;  // two bits of edge mode
    localparam int CFG_SRC_BIT   = 2;  // 1 selects phase fine source
    localparam int CFG_SHDW_BIT  = 3;  // 1 loads duty fine immediately
    localparam int DIAG_GO_BIT   = 0;
    localparam int STAT_OK_BIT   = 0;
    localparam int STAT_DONE_BIT = 1;
    // reset values
    localparam logic [7:0]  STEP_RST = 8'h00;
    localparam logic [3:0]  CFG_RST  = 4'h0;
    // timing of the self-check window
    localparam int CLK_PERIOD_NS  = 100;
    localparam int DIAG_WINDOW_NS = 10000;
    localparam int DIAG_CYCLES    = DIAG_WINDOW_NS / CLK_PERIOD_NS;
    // edge mode encodings
    typedef enum logic [1:0] {
        EDGE_OFF     = 2'h0,
        RISING_ONLY  = 2'h1,
        FALLING_ONLY = 2'h2,
        BOTH_EDGES   = 2'h3
    } edge_mode_t;
    // self-check states
    typedef enum logic [2:0] {
        DIAG_IDLE = 3'b001,
        DIAG_RUN  = 3'b010,
        DIAG_DONE = 3'b100
    } diag_state_t;
    // register port request
    typedef struct packed {
        logic [5:0]  addr;
        logic [15:0] wdata;
        logic        wr;
        logic        rd;
    } reg_req_t;
    // step command to the micro edge stepper delay line
    typedef struct packed {
        logic [7:0] rise_step;
        logic [7:0] fall_step;
    } fine_edge_cmd_t;
endpackage
`default_nettype wire

// File: fine_edge_pwm_extension.sv
// Overview of operation
// - split a coarse clock into delay steps; shift edges by chosen step count
// - edge placed at one of 256 steps chosen by an 8-bit value
// - duty control takes its step count from the duty fine extension
// - both fine extensions are 8 bits, low extension of 16-bit coarse partners
// - only channel A gets fine edges; channel B stays clock resolution
// - phase fine extension at word 0x0002, unshadowed, write acts at once
// - duty fine extension at word 0x0008 with optional shadowed loading
// - config at 0x0020, unshadowed, written only while protected writes permitted
// - config picks rising only, falling only or both edges
// - config picks duty fine or phase fine as step source
// - shadow option acts only on duty fine, none when phase selected
// - self-check mode tells whether the stepper runs optimally
// - duty fine step comes from high byte; low byte ignored
`default_nettype none
module fine_edge_pwm_extension
    import fine_edge_pkg::*;
#(
    parameter logic [7:0] MIN_TAPS = 8'h20
) (
    input  wire logic            core_clk_in,
    input  wire logic            rst_b_in,
    input  wire reg_req_t        reg_req_in,
    input  wire logic            protected_write_permit_in,
    input  wire logic            duty_load_in,
    input  wire logic            coarse_a_in,
    input  wire logic            coarse_b_in,
    input  wire logic [7:0]      cal_taps_in,
    output var  logic [15:0]     rdata_out,
    output var  logic            channel_a_output_out,
    output var  logic            channel_b_output_out,
    output var  fine_edge_cmd_t  edge_cmd_out
);
    localparam int DIAG_BOUND = DIAG_CYCLES + 2;

    logic [7:0]     phase_fine;
    logic [7:0]     duty_shadow;
    logic [7:0]     duty_active;
    logic [3:0]     config_bits;
    logic [15:0]    next_rdata;
    logic [7:0]     next_phase_fine;
    logic [7:0]     next_duty_shadow;
    logic [7:0]     next_duty_active;
    logic [3:0]     next_config_bits;
    edge_mode_t     edge_mode;
    logic           src_phase;
    logic           immediate_load;
    logic [7:0]     step_src;
    fine_edge_cmd_t next_edge_cmd;
    logic           next_chan_a;
    logic           next_chan_b;
    diag_state_t    diag_state;
    diag_state_t    next_diag_state;
    logic [7:0]     diag_cnt;
    logic [7:0]     next_diag_cnt;
    logic [7:0]     taps_min;
    logic [7:0]     taps_max;
    logic [7:0]     next_taps_min;
    logic [7:0]     next_taps_max;
    logic           diag_ok;
    logic           next_diag_ok;
    logic           wr_phase;
    logic           wr_duty;
    logic           wr_cfg;
    logic           diag_go;

    // config field decode
    assign edge_mode      = edge_mode_t'(config_bits[CFG_EDGE_LSB +: 2]);
    assign src_phase      = config_bits[CFG_SRC_BIT];
    assign immediate_load = config_bits[CFG_SHDW_BIT];
    assign wr_phase = reg_req_in.wr && (reg_req_in.addr == OFS_PHASE_FINE);
    assign wr_duty  = reg_req_in.wr && (reg_req_in.addr == OFS_DUTY_FINE);
    assign wr_cfg   = reg_req_in.wr && (reg_req_in.addr == OFS_CONFIG);
    assign diag_go  = reg_req_in.wr && (reg_req_in.addr == OFS_DIAG_CTRL)
                      && reg_req_in.wdata[DIAG_GO_BIT];

    // register writes, duty shadowing and read mux
    always_comb begin
        next_phase_fine  = phase_fine;
        next_duty_shadow = duty_shadow;
        next_duty_active = duty_active;
        next_config_bits = config_bits;
        next_rdata       = 16'h0000;
        if (wr_phase) begin
            next_phase_fine = reg_req_in.wdata[STEP_LSB +: 8];
        end
        if (wr_duty) begin
            next_duty_shadow = reg_req_in.wdata[STEP_LSB +: 8];
        end
        // shadow option only steers the duty path
        if (immediate_load || src_phase) begin
            next_duty_active = next_duty_shadow;
        end else if (duty_load_in) begin
            next_duty_active = duty_shadow;
        end
        if (wr_cfg && protected_write_permit_in) begin
            next_config_bits = reg_req_in.wdata[3:0];
        end
        if (reg_req_in.rd) begin
            unique case (reg_req_in.addr)
                OFS_PHASE_FINE: next_rdata = {phase_fine, 8'h00};
                OFS_DUTY_FINE:  next_rdata = {duty_shadow, 8'h00};
                OFS_CONFIG:     next_rdata = {12'h000, config_bits};
                OFS_DIAG_STAT:  next_rdata = {taps_min, 6'h00,
                                              diag_state == DIAG_DONE, diag_ok};
                default:        next_rdata = 16'h0000;
            endcase
        end
    end

    // register state
    always_ff @(posedge core_clk_in) begin
        if (!rst_b_in) begin
            phase_fine  <= STEP_RST;
            duty_shadow <= STEP_RST;
            duty_active <= STEP_RST;
            config_bits <= CFG_RST;
            rdata_out   <= 16'h0000;
        end else begin
            phase_fine  <= next_phase_fine;
            duty_shadow <= next_duty_shadow;
            duty_active <= next_duty_active;
            config_bits <= next_config_bits;
            rdata_out   <= next_rdata;
        end
    end

    // step selection and edge command for the delay line
    always_comb begin
        step_src = src_phase ? phase_fine : duty_active;
        next_edge_cmd = '0;
        unique case (edge_mode)
            RISING_ONLY:  next_edge_cmd.rise_step = step_src;
            FALLING_ONLY: next_edge_cmd.fall_step = step_src;
            BOTH_EDGES: begin
                next_edge_cmd.rise_step = step_src;
                next_edge_cmd.fall_step = step_src;
            end
            EDGE_OFF:     next_edge_cmd = '0;
        endcase
        next_chan_a = coarse_a_in; // delay line shifts this edge
        next_chan_b = coarse_b_in;
    end

    // output flops, aligned with channel A coarse edge
    always_ff @(posedge core_clk_in) begin
        if (!rst_b_in) begin
            edge_cmd_out         <= '0;
            channel_a_output_out <= 1'b0;
            channel_b_output_out <= 1'b0;
        end else begin
            edge_cmd_out         <= next_edge_cmd;
            channel_a_output_out <= next_chan_a;
            channel_b_output_out <= next_chan_b;
        end
    end

    // self-check: watch stepper taps per clock over a window
    always_comb begin
        next_diag_state = diag_state;
        next_diag_cnt   = diag_cnt;
        next_taps_min   = taps_min;
        next_taps_max   = taps_max;
        next_diag_ok    = diag_ok;
        unique case (diag_state)
            DIAG_IDLE, DIAG_DONE: begin
                if (diag_go) begin
                    next_diag_state = DIAG_RUN;
                    next_diag_cnt   = 8'h00;
                    next_taps_min   = 8'hFF;
                    next_taps_max   = 8'h00;
                    next_diag_ok    = 1'b0;
                end
            end
            DIAG_RUN: begin
                next_diag_cnt = diag_cnt + 8'h01;
                if (cal_taps_in < taps_min) begin
                    next_taps_min = cal_taps_in;
                end
                if (cal_taps_in > taps_max) begin
                    next_taps_max = cal_taps_in;
                end
                if (diag_cnt == 8'(DIAG_CYCLES - 1)) begin
                    next_diag_state = DIAG_DONE;
                    next_diag_ok = (next_taps_max - next_taps_min <= 8'h01)
                                   && (next_taps_min >= MIN_TAPS);
                end
            end
            default: next_diag_state = DIAG_IDLE;
        endcase
    end

    // self-check state
    always_ff @(posedge core_clk_in) begin
        if (!rst_b_in) begin
            diag_state <= DIAG_IDLE;
            diag_cnt   <= 8'h00;
            taps_min   <= 8'h00;
            taps_max   <= 8'h00;
            diag_ok    <= 1'b0;
        end else begin
            diag_state <= next_diag_state;
            diag_cnt   <= next_diag_cnt;
            taps_min   <= next_taps_min;
            taps_max   <= next_taps_max;
            diag_ok    <= next_diag_ok;
        end
    end

    // checks on the block's own behaviour
    default clocking cb @(posedge core_clk_in); endclocking
    default disable iff (!rst_b_in);

    sequence diag_start_s;
        (diag_state != DIAG_RUN) && diag_go;
    endsequence

    sequence diag_finish_s;
        diag_state == DIAG_DONE;
    endsequence

    AST_DIAG_FINISHES: assert property (diag_start_s |-> ##[1:DIAG_BOUND] diag_finish_s)
        else $error("self-check did not finish in its window");

    AST_DIAG_RUN_LEN: assert property (diag_start_s |=> (diag_state == DIAG_RUN)[*8])
        else $error("self-check ended too early");

    AST_ZERO_STEP: assert property ((step_src == 8'h00) |=> (edge_cmd_out == '0))
        else $error("zero step moved the channel A edge");

    AST_CHAN_B_COARSE: assert property (##1 channel_b_output_out == $past(coarse_b_in))
        else $error("channel B not plain coarse PWM");

    AST_PHASE_DIRECT: assert property (wr_phase |=> phase_fine == $past(reg_req_in.wdata[15:8]))
        else $error("phase fine write not taken at once");

    AST_CFG_LOCKED: assert property (wr_cfg && !protected_write_permit_in |=> $stable(config_bits))
        else $error("config changed without write permit");

    AST_SHADOW_HOLD: assert property (!immediate_load && !src_phase && !duty_load_in
                                      |=> $stable(duty_active))
        else $error("shadowed duty step changed without load");

    AST_SHADOW_LOAD: assert property (!immediate_load && !src_phase && duty_load_in
                                      |=> duty_active == $past(duty_shadow))
        else $error("duty step not loaded from shadow");

    AST_RISE_ONLY: assert property (edge_mode == RISING_ONLY
                                    |=> edge_cmd_out.fall_step == 8'h00
                                        && edge_cmd_out.rise_step == $past(step_src))
        else $error("rising only mode moved the falling edge");

    AST_PHASE_SRC: assert property (src_phase && edge_mode == BOTH_EDGES
                                    |=> edge_cmd_out.fall_step == $past(phase_fine))
        else $error("phase source not applied");

    AST_LOW_BYTE_ZERO: assert property (reg_req_in.rd && reg_req_in.addr == OFS_DUTY_FINE
                                        |=> rdata_out[7:0] == 8'h00)
        else $error("duty fine low byte not ignored");

endmodule
`default_nettype wire

// File: power_stage_model.sv
`default_nettype none
// power stage: latches the fine step in force at each channel A turn-on
module power_stage_model
    import fine_edge_pkg::*;
(
    input  wire logic           clk_in,
    input  wire logic           gate_a_in,
    input  wire fine_edge_cmd_t cmd_in,
    output var  logic [7:0]     rise_step_out
);
    timeunit 1ns;
    timeprecision 1ns;
    logic gate_a_q = 1'b0;
    // only channel A carries a fine step to the switch
    always @(posedge clk_in) begin
        gate_a_q <= gate_a_in;
        if (gate_a_in && !gate_a_q) begin
            rise_step_out <= cmd_in.rise_step;
        end
    end
endmodule
`default_nettype wire

// File: tb.sv
`default_nettype none
module tb
    import fine_edge_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    logic           core_clk_in = 1'b0;
    logic           rst_b_in    = 1'b0;
    logic           permit      = 1'b0;
    logic           duty_load   = 1'b0;
    logic           coarse_a    = 1'b0;
    logic           coarse_b    = 1'b0;
    logic [7:0]     cal_taps    = 8'h30;
    reg_req_t       req         = '0;
    logic [15:0]    rdata;
    logic           cha;
    logic           chb;
    fine_edge_cmd_t cmd;
    logic [7:0]     seen_step;
    int             n_errors    = 0;
    int             comparisons = 0;

    always #50 core_clk_in = ~core_clk_in;

    fine_edge_pwm_extension i_fine_edge_pwm_extension (
        .core_clk_in(core_clk_in), .rst_b_in(rst_b_in), .reg_req_in(req),
        .protected_write_permit_in(permit), .duty_load_in(duty_load),
        .coarse_a_in(coarse_a), .coarse_b_in(coarse_b), .cal_taps_in(cal_taps),
        .rdata_out(rdata), .channel_a_output_out(cha), .channel_b_output_out(chb),
        .edge_cmd_out(cmd));
    power_stage_model i_power_stage_model (
        .clk_in(core_clk_in), .gate_a_in(cha), .cmd_in(cmd), .rise_step_out(seen_step));

    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        comparisons++;
        if (got !== exp) begin
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
            n_errors++;
        end
    endtask
    task automatic wr(input logic [5:0] a, input logic [15:0] d);
        @(posedge core_clk_in);
        req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge core_clk_in);
        req.wr <= 1'b0;
    endtask
    task automatic rd(input logic [5:0] a, output logic [15:0] d);
        @(posedge core_clk_in);
        req <= '{addr: a, wdata: 16'h0000, wr: 1'b0, rd: 1'b1};
        @(posedge core_clk_in);
        req.rd <= 1'b0;
        #1 d = rdata;
    endtask
    task automatic rc(input string what, input logic [5:0] a, input logic [15:0] exp);
        logic [15:0] d;
        rd(a, d);
        chk(what, exp, d);
    endtask
    task automatic settle;
        repeat (3) @(posedge core_clk_in);
        #1;
    endtask
    // coarse pulse on both channels, stage sees the fine step
    task automatic pulse(input logic [7:0] step);
        @(posedge core_clk_in);
        coarse_a <= 1'b1;
        coarse_b <= 1'b1;
        @(posedge core_clk_in);
        #1 chk("channels", 16'h0003, {14'h0000, cha, chb});
        @(posedge core_clk_in);
        coarse_a <= 1'b0;
        coarse_b <= 1'b0;
        #1 chk("stage step", {8'h00, step}, {8'h00, seen_step});
    endtask

    task automatic t_regs;
        rc("phase reset", OFS_PHASE_FINE, 16'h0000);
        rc("duty reset", OFS_DUTY_FINE, 16'h0000);
        rc("config reset", OFS_CONFIG, 16'h0000);
        wr(OFS_PHASE_FINE, 16'h12AB);
        rc("phase", OFS_PHASE_FINE, 16'h1200);
        wr(OFS_DUTY_FINE, 16'h1780);
        rc("duty", OFS_DUTY_FINE, 16'h1700);
        rc("unmapped", 6'h3F, 16'h0000);
        $display("test regs done");
    endtask
    task automatic t_protect;
        wr(OFS_CONFIG, 16'h0005);
        rc("config locked", OFS_CONFIG, 16'h0000);
        @(posedge core_clk_in);
        permit <= 1'b1;
        wr(OFS_CONFIG, 16'h0005);
        rc("config open", OFS_CONFIG, 16'h0005);
        $display("test protect done");
    endtask
    task automatic t_modes;
        logic [3:0]  cfgs [5] = '{4'h8, 4'h9, 4'hA, 4'h1, 4'hF};
        logic [15:0] exps [5] = '{16'h0000, 16'h1700, 16'h0017, 16'h1700, 16'h1212};
        wr(OFS_CONFIG, 16'h0008);
        wr(OFS_DUTY_FINE, 16'h1780);
        for (int i = 0; i < 5; i++) begin
            wr(OFS_CONFIG, {12'h000, cfgs[i]});
            settle();
            chk("edge cmd", exps[i], cmd);
            pulse(exps[i][15:8]);
        end
        $display("test modes done");
    endtask
    task automatic t_shadow;
        wr(OFS_CONFIG, 16'h0009);
        wr(OFS_DUTY_FINE, 16'h2000);
        wr(OFS_CONFIG, 16'h0001);
        wr(OFS_DUTY_FINE, 16'h4000);
        settle();
        chk("duty held", 16'h2000, cmd);
        @(posedge core_clk_in);
        duty_load <= 1'b1;
        @(posedge core_clk_in);
        duty_load <= 1'b0;
        settle();
        chk("duty loaded", 16'h4000, cmd);
        wr(OFS_CONFIG, 16'h0005);
        wr(OFS_PHASE_FINE, 16'h3300);
        wr(OFS_DUTY_FINE, 16'h5500);
        settle();
        chk("phase direct", 16'h3300, cmd);
        wr(OFS_CONFIG, 16'h0001);
        settle();
        chk("duty unshadowed", 16'h5500, cmd);
        $display("test shadow done");
    endtask
    task automatic t_diag;
        logic [15:0] d;
        logic [7:0]  taps [2] = '{8'h30, 8'h10};
        for (int i = 0; i < 2; i++) begin
            @(posedge core_clk_in);
            cal_taps <= taps[i];
            wr(OFS_DIAG_CTRL, 16'h0001);
            for (int n = 0; n < 150; n++) begin
                rd(OFS_DIAG_STAT, d);
                if (d[STAT_DONE_BIT] === 1'b1) break;
            end
            chk("diag status", {taps[i], 7'h01, (i == 0)}, d);
        end
        $display("test diag done");
    endtask

    task automatic give_verdict;
        $display("counts: %0d mismatches, %0d comparisons", n_errors, comparisons);
        if (n_errors == 0 && comparisons > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask

    initial begin
        #(4000 * 100);
        n_errors++;
        give_verdict();
    end
    initial begin
        repeat (2) @(posedge core_clk_in);
        rst_b_in <= 1'b1;
        t_regs();
        t_protect();
        t_modes();
        t_shadow();
        t_diag();
        give_verdict();
    end
endmodule
`default_nettype wire
